// ---- core/dpt_pkg.sv ----
// Package of constants and types for the dual PWM buffered compare timer
// Operation
// - Run cleared: stop, counter FFFFH, outputs default
// - Early clear before count tick suppresses interrupt
// - Clear on tick: match still acts, then stop
// - Compares are holding stage plus working buffer
// - Transfer on start, period match, external trigger
// - Period equals period compare plus one
// - Output A duty is duty over period
// - Output B active between start and end
// - Start: FFFFH to 0000H, interrupt, A active
// - Counter equals A duty: A inactive
// - B active at start, inactive at end; with start 0000H, B stays inactive until the first period match
// - Period match: interrupt, A active, restart
// - Start copies all holding values to buffers
// - Reload request while stopped sets pending; start clears
// - Reload request running: transfer at period match
// - No request: buffers unchanged at matches
// - Counter holds FFFFH stopped, then wraps upward
package dpt_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_RELOAD   = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_PERIOD   = 8'h0c;
	localparam logic [7:0] OFS_DUTY_A   = 8'h10;
	localparam logic [7:0] OFS_START_B  = 8'h14;
	localparam logic [7:0] OFS_END_B    = 8'h18;
	localparam logic [7:0] OFS_TRIG     = 8'h1c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_COUNT    = 8'h28;
	localparam logic [7:0] OFS_PRESCALE = 8'h2c;

	// Control register fields
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_DEF_A = 1;
	localparam int CTRL_DEF_B = 2;
	localparam int CTRL_ACT_A = 3;
	localparam int CTRL_ACT_B = 4;
	localparam int CTRL_TRGE  = 5;

	// Reset and counter values
	localparam logic [15:0] CNT_IDLE   = 16'hffff;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CMP_RST    = 16'h0000;
	localparam logic [7:0]  PRESC_RST  = 8'h00;

	// Compare set: holding or working
	typedef struct packed {
		logic [15:0] period;
		logic [15:0] duty_a;
		logic [15:0] start_b;
		logic [15:0] end_b;
		logic [15:0] trig;
	} dpt_cmp_t;

	// Bus handshake states
	typedef enum logic [1:0] {
		BS_IDLE = 2'b00,
		BS_RESP = 2'b01
	} dpt_bus_st_t;

	// Whole module state
	typedef struct packed {
		dpt_bus_st_t wst;
		dpt_bus_st_t rst;
		logic        have_aw;
		logic        have_w;
		logic [7:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [5:0]  ctrl;
		logic        running;
		logic        pending;
		logic        irq_stat;
		logic        irq_mask;
		logic        irq;
		logic [7:0]  presc;
		logic [7:0]  div;
		logic [15:0] cnt;
		logic        out_a;
		logic        out_b;
		logic        pwm_a;
		logic        pwm_b;
		dpt_cmp_t    hold;
		dpt_cmp_t    work;
	} dpt_state_t;

endpackage : dpt_pkg

// ---- core/dpt_timer.sv ----
// Dual PWM buffered compare timer with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module dpt_timer (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	// External reload trigger, one-cycle pulse
	input  wire logic        ext_trig_i,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Timer outputs
	output logic             pwm_out_a_o,
	output logic             pwm_out_b_o,
	output logic             period_irq_o
);

	dpt_pkg::dpt_state_t s_q, s_d;

	// Merge a write into a 16-bit field by byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) r[7:0] = wd[7:0];
		if (be[1]) r[15:8] = wd[15:8];
		return r;
	endfunction : merge16

	// Drive pin from level select and output state
	function automatic logic pin_level(input logic run_en, input logic act,
		input logic def_lvl, input logic act_low);
		return run_en ? (act ^ act_low) : def_lvl;
	endfunction : pin_level

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from state flops
	assign s_axi_awready_o = (s_q.wst == dpt_pkg::BS_IDLE) && !s_q.have_aw;
	assign s_axi_wready_o  = (s_q.wst == dpt_pkg::BS_IDLE) && !s_q.have_w;
	assign s_axi_bvalid_o  = s_q.bvalid;
	assign s_axi_bresp_o   = s_q.bresp;
	assign s_axi_arready_o = (s_q.rst == dpt_pkg::BS_IDLE);
	assign s_axi_rvalid_o  = s_q.rvalid;
	assign s_axi_rresp_o   = s_q.rresp;
	assign s_axi_rdata_o   = s_q.rdata;
	assign pwm_out_a_o     = s_q.pwm_a;
	assign pwm_out_b_o     = s_q.pwm_b;
	assign period_irq_o    = s_q.irq;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic        wr_go;
		logic        rel_req;
		logic        tick;
		logic        start;
		logic        pmatch;
		logic        irq_ev;
		logic        xfer;
		logic        run_bit;
		logic [31:0] rd;
		logic [1:0]  rr;
		wr_go   = 1'b0;
		rel_req = 1'b0;
		tick    = 1'b0;
		start   = 1'b0;
		pmatch  = 1'b0;
		irq_ev  = 1'b0;
		xfer    = 1'b0;
		run_bit = 1'b0;
		rd      = 32'h0000_0000;
		rr      = 2'b00;
		s_d     = s_q;

		// Write address and data, either order
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			s_d.have_aw = 1'b1;
			s_d.waddr   = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			s_d.have_w = 1'b1;
			s_d.wdata  = s_axi_wdata_i;
			s_d.wstrb  = s_axi_wstrb_i;
		end
		if (s_q.wst == dpt_pkg::BS_IDLE && s_q.have_aw && s_q.have_w) begin
			wr_go      = 1'b1;
			s_d.have_aw = 1'b0;
			s_d.have_w  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = 2'b00;
			s_d.wst     = dpt_pkg::BS_RESP;
		end
		if (s_q.wst == dpt_pkg::BS_RESP && s_axi_bready_i) begin
			s_d.bvalid = 1'b0;
			s_d.wst    = dpt_pkg::BS_IDLE;
		end

		// Register writes: compares to holding stage only
		if (wr_go) begin
			unique case (s_q.waddr)
				dpt_pkg::OFS_CTRL:
					if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[5:0];
				dpt_pkg::OFS_RELOAD:
					rel_req = s_q.wstrb[0] && s_q.wdata[0];
				dpt_pkg::OFS_PERIOD:
					s_d.hold.period = merge16(s_q.hold.period, s_q.wdata, s_q.wstrb);
				dpt_pkg::OFS_DUTY_A:
					s_d.hold.duty_a = merge16(s_q.hold.duty_a, s_q.wdata, s_q.wstrb);
				dpt_pkg::OFS_START_B:
					s_d.hold.start_b = merge16(s_q.hold.start_b, s_q.wdata, s_q.wstrb);
				dpt_pkg::OFS_END_B:
					s_d.hold.end_b = merge16(s_q.hold.end_b, s_q.wdata, s_q.wstrb);
				dpt_pkg::OFS_TRIG:
					s_d.hold.trig = merge16(s_q.hold.trig, s_q.wdata, s_q.wstrb);
				dpt_pkg::OFS_IRQ_MASK:
					if (s_q.wstrb[0]) s_d.irq_mask = s_q.wdata[0];
				dpt_pkg::OFS_PRESCALE:
					if (s_q.wstrb[0]) s_d.presc = s_q.wdata[7:0];
				default: ;
			endcase
		end
		run_bit = s_d.ctrl[dpt_pkg::CTRL_RUN];

		// Count clock: one tick every presc+1 system clocks
		if (s_q.div == s_q.presc) begin
			tick    = 1'b1;
			s_d.div = 8'h00;
		end else begin
			s_d.div = s_q.div + 8'h01;
		end

		// Counter: idle holds FFFFH, start wraps to zero
		if (!s_q.running) begin
			s_d.cnt   = dpt_pkg::CNT_IDLE;
			s_d.out_a = 1'b0;
			s_d.out_b = 1'b0;
			if (s_q.ctrl[dpt_pkg::CTRL_RUN] && tick) begin
				start       = 1'b1;
				s_d.running = 1'b1;
				s_d.cnt     = dpt_pkg::CNT_ZERO;
				// A goes active at start unless its duty is zero
				s_d.out_a   = (s_d.hold.duty_a != dpt_pkg::CNT_ZERO);
				irq_ev      = 1'b1;
				xfer        = 1'b1;
			end
		end else if (!s_q.ctrl[dpt_pkg::CTRL_RUN]) begin
			// Stop one system clock after clear; no tick taken
			s_d.running = 1'b0;
			s_d.cnt     = dpt_pkg::CNT_IDLE;
			s_d.out_a   = 1'b0;
			s_d.out_b   = 1'b0;
		end else if (tick) begin
			// Tick with run still set, even if cleared now
			if (s_q.cnt == s_q.work.period) begin
				pmatch    = 1'b1;
				s_d.cnt   = dpt_pkg::CNT_ZERO;
				s_d.out_a = 1'b1;
				irq_ev    = 1'b1;
				xfer      = s_q.pending;
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
			// Duty compares on the next count
			if (s_q.cnt + 16'h0001 == s_q.work.duty_a && !pmatch)
				s_d.out_a = 1'b0;
			if (pmatch && s_q.work.duty_a == dpt_pkg::CNT_ZERO)
				s_d.out_a = 1'b0;
			// Output B window
			if (pmatch) begin
				s_d.out_b = (s_q.work.start_b == dpt_pkg::CNT_ZERO) &&
					(s_q.work.end_b != dpt_pkg::CNT_ZERO);
			end else if (s_q.cnt + 16'h0001 == s_q.work.end_b) begin
				s_d.out_b = 1'b0;
			end else if (s_q.cnt + 16'h0001 == s_q.work.start_b) begin
				s_d.out_b = 1'b1;
			end
		end

		// External trigger reload when enabled
		if (s_q.running && s_q.ctrl[dpt_pkg::CTRL_TRGE] && ext_trig_i && s_q.pending)
			xfer = 1'b1;
		if (start)
			xfer = 1'b1;

		// Batch transfer of every compare at once
		if (xfer)
			s_d.work = s_d.hold;

		// Pending flag: request sets, start or transfer clears
		if (start || (xfer && (pmatch || s_q.running)))
			s_d.pending = 1'b0;
		if (rel_req)
			s_d.pending = 1'b1;

		// Sticky event status, write one to clear, set wins
		if (wr_go && s_q.waddr == dpt_pkg::OFS_IRQ_STAT && s_q.wstrb[0] && s_q.wdata[0])
			s_d.irq_stat = 1'b0;
		if (irq_ev)
			s_d.irq_stat = 1'b1;
		s_d.irq = s_d.irq_stat && s_d.irq_mask;

		// Pin levels, default while stopped
		s_d.pwm_a = pin_level(s_d.running, s_d.out_a, s_d.ctrl[dpt_pkg::CTRL_DEF_A],
			s_d.ctrl[dpt_pkg::CTRL_ACT_A]);
		s_d.pwm_b = pin_level(s_d.running, s_d.out_b, s_d.ctrl[dpt_pkg::CTRL_DEF_B],
			s_d.ctrl[dpt_pkg::CTRL_ACT_B]);
		if (run_bit && !s_q.running && !start) begin
			s_d.pwm_a = s_d.ctrl[dpt_pkg::CTRL_DEF_A];
		end

		// Read channel
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			unique case (s_axi_araddr_i)
				dpt_pkg::OFS_CTRL:     rd = {26'h0, s_q.ctrl};
				dpt_pkg::OFS_RELOAD:   rd = 32'h0000_0000;
				dpt_pkg::OFS_STATUS:   rd = {30'h0, s_q.running, s_q.pending};
				dpt_pkg::OFS_PERIOD:   rd = {16'h0, s_q.hold.period};
				dpt_pkg::OFS_DUTY_A:   rd = {16'h0, s_q.hold.duty_a};
				dpt_pkg::OFS_START_B:  rd = {16'h0, s_q.hold.start_b};
				dpt_pkg::OFS_END_B:    rd = {16'h0, s_q.hold.end_b};
				dpt_pkg::OFS_TRIG:     rd = {16'h0, s_q.hold.trig};
				dpt_pkg::OFS_IRQ_STAT: rd = {31'h0, s_q.irq_stat};
				dpt_pkg::OFS_IRQ_MASK: rd = {31'h0, s_q.irq_mask};
				dpt_pkg::OFS_COUNT:    rd = {16'h0, s_q.cnt};
				dpt_pkg::OFS_PRESCALE: rd = {24'h0, s_q.presc};
				default:               rr = 2'b10;
			endcase
			s_d.rdata  = rd;
			s_d.rresp  = rr;
			s_d.rvalid = 1'b1;
			s_d.rst    = dpt_pkg::BS_RESP;
		end
		if (s_q.rst == dpt_pkg::BS_RESP && s_axi_rready_i) begin
			s_d.rvalid = 1'b0;
			s_d.rst    = dpt_pkg::BS_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s_q          <= '0;
			s_q.wst      <= dpt_pkg::BS_IDLE;
			s_q.rst      <= dpt_pkg::BS_IDLE;
			s_q.cnt      <= dpt_pkg::CNT_IDLE;
			s_q.presc    <= dpt_pkg::PRESC_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : dpt_timer

// ---- verification/dpt_timer_monitor.sv ----
// Port-level assertions for the dual PWM timer
`timescale 1ns/1ns
module dpt_timer_monitor (
	// Clock and reset
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	// Register bus
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// Timer outputs
	input wire logic        pwm_out_a_o,
	input wire logic        pwm_out_b_o,
	input wire logic        period_irq_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Both write halves accepted, then an OKAY answer
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_wr_resp;
		s_axi_bvalid_o && s_axi_bresp_o == 2'h0;
	endsequence
	a_reset_quiet: assert property ($fell(sys_rst_i) |->
		!pwm_out_a_o && !pwm_out_b_o && !period_irq_o && s_axi_awready_o && s_axi_arready_o)
		else $error("outputs not idle after reset");
	a_write_answer: assert property (s_wr_take |-> ##2 s_wr_resp)
		else $error("write not answered");
	a_write_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
		else $error("address taken with answer pending");
	a_bresp_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write answer repeated");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read not answered");
	a_read_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken with data pending");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o))
		else $error("read data moved");
	a_irq_drop: assert property ($fell(period_irq_o) |-> s_axi_bvalid_o ||
		$past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2))
		else $error("interrupt fell without a write");
endmodule : dpt_timer_monitor

// ---- verification/tb_top.sv ----
// Self-checking bench for the dual PWM timer
`timescale 1ns/1ns
module tb_top;
	logic        clk = 1'h0, rst = 1'h1, trig = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, got, na, nb;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, pa, pb, irq;
	logic [1:0]  bresp, rresp, rsp;
	logic [15:0] tc [5][6] = '{'{16'h1, 16'h2, 16'h1, 16'h2, 16'h8, 16'h4},
		'{16'h1, 16'h0, 16'h2, 16'h2, 16'h0, 16'h0}, '{16'h1, 16'h4, 16'h0, 16'h4, 16'h10, 16'h10},
		'{16'h9, 16'h1, 16'h0, 16'h3, 16'hc, 16'hc}, '{16'h11, 16'h3, 16'h1, 16'h3, 16'hc, 16'h8}};
	int          errors = 0;
	int          comparisons = 0;
	dpt_timer dut (.clk_sys_i(clk), .sys_rst_i(rst), .ext_trig_i(trig),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pwm_out_a_o(pa),
		.pwm_out_b_o(pb), .period_irq_o(irq));
	////////////////////////////////////////////////////////////////////////////////
	// Verdict and exit
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			errors++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	// Bus write, answer awaited under a bound
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'h0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			done = bvalid;
			rsp = bresp;
		end
		bready <= 1'h0;
		if (!done) errors++;
	endtask : wr
	// Bus read, data and response taken at the answer edge
	task automatic rd(input logic [7:0] a);
		logic done;
		done = 1'h0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			done = rvalid;
			got = rdata;
			rsp = rresp;
		end
		rready <= 1'h0;
		if (!done) errors++;
	endtask : rd
	// High time of both outputs over four periods
	task automatic meas;
		na = 32'h0;
		nb = 32'h0;
		repeat (16) begin
			@(posedge clk);
			na = na + pa;
			nb = nb + pb;
		end
	endtask : meas
	////////////////////////////////////////////////////////////////////////////////
	// Reset values and unmapped read
	task automatic t_reset;
		rd(dpt_pkg::OFS_COUNT);
		chk(got, {16'h0, dpt_pkg::CNT_IDLE});
		rd(dpt_pkg::OFS_STATUS);
		chk(got, 32'h0);
		rd(8'h30);
		chk({30'h0, rsp}, 32'h2);
	endtask : t_reset
	// Duty boundaries and levels, compares loaded at start
	task automatic t_duty;
		wr(dpt_pkg::OFS_IRQ_MASK, 32'h1);
		for (int k = 0; k < 5; k++) begin
			wr(dpt_pkg::OFS_PERIOD, 32'h3);
			wr(dpt_pkg::OFS_DUTY_A, {16'h0, tc[k][1]});
			wr(dpt_pkg::OFS_START_B, {16'h0, tc[k][2]});
			wr(dpt_pkg::OFS_END_B, {16'h0, tc[k][3]});
			wr(dpt_pkg::OFS_CTRL, {16'h0, tc[k][0]});
			repeat (6) @(posedge clk);
			chk({31'h0, irq}, 32'h1);
			meas;
			chk(na, {16'h0, tc[k][4]});
			chk(nb, {16'h0, tc[k][5]});
			wr(dpt_pkg::OFS_CTRL, 32'h0);
		end
	endtask : t_duty
	// Held compares and requested reload
	task automatic t_reload;
		wr(dpt_pkg::OFS_DUTY_A, 32'h2);
		wr(dpt_pkg::OFS_CTRL, 32'h1);
		wr(dpt_pkg::OFS_DUTY_A, 32'h1);
		repeat (6) @(posedge clk);
		meas;
		chk(na, 32'h8);
		wr(dpt_pkg::OFS_RELOAD, 32'h1);
		repeat (6) @(posedge clk);
		meas;
		chk(na, 32'h4);
		rd(dpt_pkg::OFS_STATUS);
		chk(got, 32'h2);
		wr(dpt_pkg::OFS_CTRL, 32'h0);
		wr(dpt_pkg::OFS_RELOAD, 32'h1);
		rd(dpt_pkg::OFS_STATUS);
		chk(got, 32'h1);
		wr(dpt_pkg::OFS_CTRL, 32'h1);
		rd(dpt_pkg::OFS_STATUS);
		chk(got, 32'h2);
	endtask : t_reload
	// Stop, default levels, interrupt mask and clear
	task automatic t_stop;
		wr(dpt_pkg::OFS_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk({30'h0, pa, pb}, 32'h0);
		rd(dpt_pkg::OFS_COUNT);
		chk(got, {16'h0, dpt_pkg::CNT_IDLE});
		wr(dpt_pkg::OFS_IRQ_STAT, 32'h1);
		repeat (10) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(dpt_pkg::OFS_CTRL, 32'h6);
		repeat (3) @(posedge clk);
		chk({30'h0, pa, pb}, 32'h3);
		wr(dpt_pkg::OFS_CTRL, 32'h1);
		wr(dpt_pkg::OFS_IRQ_MASK, 32'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(dpt_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(dpt_pkg::OFS_CTRL, 32'h0);
	endtask : t_stop
	// External trigger reload with a long period
	task automatic t_trig;
		wr(dpt_pkg::OFS_PERIOD, 32'h40);
		wr(dpt_pkg::OFS_DUTY_A, 32'h2);
		wr(dpt_pkg::OFS_CTRL, 32'h21);
		chk({30'h0, rsp}, 32'h0);
		wr(dpt_pkg::OFS_DUTY_A, 32'h30);
		wr(dpt_pkg::OFS_RELOAD, 32'h1);
		rd(dpt_pkg::OFS_STATUS);
		chk(got, 32'h3);
		@(posedge clk);
		trig <= 1'h1;
		@(posedge clk);
		trig <= 1'h0;
		rd(dpt_pkg::OFS_STATUS);
		chk(got, 32'h2);
		wr(dpt_pkg::OFS_CTRL, 32'h0);
	endtask : t_trig
	////////////////////////////////////////////////////////////////////////////////
	// Clock, main sequence, watchdog
	initial forever #5 clk = ~clk;
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_duty;
		t_reload;
		t_stop;
		t_trig;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end
endmodule : tb_top
// Checker attached to the timer
bind dpt_timer dpt_timer_monitor u_mon (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o), .period_irq_o(period_irq_o));
